// ===== rtl/mbcfg_defines.vh
`ifndef MBCFG_DEFINES_VH
`define MBCFG_DEFINES_VH
// Clock rate and baud rates (bits per second, with clk at 25 MHz).
`define MBCFG_CLK_HZ        25000000
`define MBCFG_BAUD_2400     2400
`define MBCFG_BAUD_4800     4800
`define MBCFG_BAUD_9600     9600
`define MBCFG_BAUD_19200    19200
`define MBCFG_BAUD_38400    38400
// Configuration codes and defaults.
`define MBCFG_BAUD_DEF      3'h3
`define MBCFG_BAUD_MAX      3'h4
`define MBCFG_PAR_EVEN      2'h0
`define MBCFG_PAR_ODD       2'h1
`define MBCFG_PAR_NONE2     2'h2
`define MBCFG_PAR_NONE1     2'h3
`define MBCFG_PAR_DEF       2'h2
`define MBCFG_MODE_LATCH    1'h0
`define MBCFG_MODE_SELFRST  1'h1
`define MBCFG_ADDR_DEF      8'h01
`define MBCFG_ADDR_MIN      8'h01
`define MBCFG_ADDR_MAX      8'hf7
`define MBCFG_CNT_MAX       15'h7fff
// Character and gap timing: 11 bit times per character, gap of 3.5 chars.
`define MBCFG_BITS_CHAR     6'h0b
`define MBCFG_GAP_HALFCHARS 4'h7
`define MBCFG_CRC_INIT      16'hffff
`define MBCFG_CRC_POLY      16'ha001
`define MBCFG_CRC_GOOD      16'h0000
`define MBCFG_FRAME_MIN     9'h004
`define MBCFG_FIFO_W        8
`define MBCFG_FIFO_D        16
`define MBCFG_FIFO_AW       4
`endif

// ===== rtl/mbcfg_fifo.v
`timescale 1ns/1ps
`default_nettype none
module mbcfg_fifo #(
  parameter W  = 8,
  parameter D  = 16,
  parameter AW = 4
) (
  // Clock, enable, reset
  input  wire          clk,
  input  wire          ce,
  input  wire          reset,
  // Fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // Drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wr_ff;
  reg [AW-1:0] rd_ff;
  reg [AW:0]   cnt_ff;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_ff != D[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (reset) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        mem[wr_ff] <= in_data;
        wr_ff      <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // mbcfg_fifo
`default_nettype wire

// ===== rtl/mbcfg_top.v
// Notes on behaviour
// - Baud codes 0..4 give 2400..38400 baud; code 3, 19200, is default.
// - Parity codes: 0 even, 1 odd, 2 none two stops, 3 none one stop.
// - Stop bits follow parity code: two for code 2, one for codes 0, 1 and 3.
// - Station address 1..247, default 1; only own-address frames are accepted.
// - RTU only; mode setting picks watchdog handling, default code 0.
// - Mode 0: watchdog expiry latches an error until power cycles.
// - Mode 1: watchdog expiry triggers an internal self-reset.
// - Written settings take effect only at the next power-up.
// - After the drive link comes up, settings are sent to the drive.
// - Module type field read-only; undefined until drive link is up.
// - Good-frame counter increments per valid frame, wraps 32767 to 0.
// - Bad-frame counter increments per communication error, wraps 32767 to 0.
// - Good count is forwarded to the drive only with new bad counts.
`timescale 1ns/1ps
`default_nettype none
`include "mbcfg_defines.vh"
module mbcfg_top #(
  parameter [15:0] MODULE_ID = 16'h5a01,  // Arbitrary identity value.
  parameter [23:0] WDG_CYCLES = 24'h2625a0
) (
  // Clock, enable, reset
  input  wire        clk,
  input  wire        ce,
  input  wire        reset,
  // Serial line
  input  wire        rx,
  // Stored settings presented at power-up
  input  wire [2:0]  cfg_baud,
  input  wire [1:0]  cfg_parity,
  input  wire [7:0]  cfg_addr,
  input  wire        cfg_mode,
  input  wire        cfg_channel,
  // Drive link
  input  wire        link_up,
  input  wire        wdg_kick,
  output reg         link_valid,
  input  wire        link_ready,
  output reg  [2:0]  link_sel,
  output reg  [15:0] link_data,
  // Accepted frame bytes
  output wire        frm_valid,
  input  wire        frm_ready,
  output wire [7:0]  frm_data,
  // Status
  output reg         wdg_error,
  output reg  [15:0] module_type,
  output reg         module_type_valid,
  output reg  [14:0] good_count,
  output reg  [14:0] bad_count,
  output reg  [2:0]  act_baud,
  output reg  [1:0]  act_parity,
  output reg  [7:0]  act_addr,
  output reg         watchdog_selfreset_mode,
  output reg         optical_channel_select
);
  localparam [1:0] RX_IDLE = 2'h0;
  localparam [1:0] RX_BITS = 2'h1;
  localparam [1:0] RX_STOP = 2'h2;

  function [15:0] half_bit;  // Cycles per half bit for a baud code.
    input [2:0]  code;
    reg   [31:0] q;
    begin
      case (code)
        3'h0:    q = (`MBCFG_CLK_HZ / `MBCFG_BAUD_2400) / 2;
        3'h1:    q = (`MBCFG_CLK_HZ / `MBCFG_BAUD_4800) / 2;
        3'h2:    q = (`MBCFG_CLK_HZ / `MBCFG_BAUD_9600) / 2;
        3'h4:    q = (`MBCFG_CLK_HZ / `MBCFG_BAUD_38400) / 2;
        default: q = (`MBCFG_CLK_HZ / `MBCFG_BAUD_19200) / 2;
      endcase
      half_bit = q[15:0];
    end
  endfunction

  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        t = t[0] ? ((t >> 1) ^ `MBCFG_CRC_POLY) : (t >> 1);
      end
      crc_byte = t;
    end
  endfunction

  // Settings are captured once after power-on reset and never again.
  reg        loaded_ff;
  reg        soft_rst_ff;
  wire       rst_all = reset | soft_rst_ff;
  reg  [1:0] rx_st_ff;
  reg [15:0] tick_ff;
  reg  [3:0] bit_ff;
  reg  [9:0] shift_ff;
  reg        stop2_ff;
  reg  [7:0] byte_cnt_ff;
  reg [15:0] crc_ff;
  reg  [3:0] gap_ff;
  reg [15:0] gap_tick_ff;
  reg        in_frame_ff;
  reg        frame_err_ff;
  reg        own_ff;
  reg [23:0] wdg_ff;
  reg        link_seen_ff;
  reg        pend_bad_ff;
  reg  [2:0] sent_ff;
  wire [15:0] hb = half_bit(act_baud);
  wire        has_par = (act_parity == `MBCFG_PAR_EVEN) || (act_parity == `MBCFG_PAR_ODD);
  wire [3:0]  nbits = has_par ? 4'h9 : 4'h8;
  // Bits enter at the top, so the data byte sits one place lower when a parity bit follows.
  wire [7:0]  rx_byte = has_par ? shift_ff[8:1] : shift_ff[9:2];
  wire        fifo_rdy;
  reg         byte_stb;
  reg  [7:0]  byte_val;

  mbcfg_fifo #(.W(`MBCFG_FIFO_W), .D(`MBCFG_FIFO_D), .AW(`MBCFG_FIFO_AW)) u_fifo (
    .clk       (clk),
    .ce        (ce),
    .reset     (rst_all),
    .in_valid  (byte_stb & own_ff),
    .in_ready  (fifo_rdy),
    .in_data   (byte_val),
    .out_valid (frm_valid),
    .out_ready (frm_ready),
    .out_data  (frm_data)
  );

  always @(posedge clk) begin
    if (reset) begin
      loaded_ff               <= 1'b0;
      act_baud                <= `MBCFG_BAUD_DEF;
      act_parity              <= `MBCFG_PAR_DEF;
      act_addr                <= `MBCFG_ADDR_DEF;
      watchdog_selfreset_mode <= `MBCFG_MODE_LATCH;
      optical_channel_select  <= 1'b0;
      wdg_error               <= 1'b0;
    end else if (ce) begin
      if (!loaded_ff) begin
        loaded_ff <= 1'b1;
        act_baud  <= (cfg_baud > `MBCFG_BAUD_MAX) ? `MBCFG_BAUD_DEF : cfg_baud;
        act_parity <= cfg_parity;
        act_addr  <= (cfg_addr < `MBCFG_ADDR_MIN || cfg_addr > `MBCFG_ADDR_MAX) ?
                     `MBCFG_ADDR_DEF : cfg_addr;
        watchdog_selfreset_mode <= cfg_mode;
        optical_channel_select  <= cfg_channel;
      end
      // Only power-on reset clears the latched error; self-reset leaves it alone.
      if (wdg_ff == WDG_CYCLES && watchdog_selfreset_mode == `MBCFG_MODE_LATCH) begin
        wdg_error <= 1'b1;
      end
    end
  end

  // Self-reset pulse restarts the receiver, counters and link but not settings.
  always @(posedge clk) begin
    if (reset) begin
      soft_rst_ff <= 1'b0;
    end else if (ce) begin
      soft_rst_ff <= (wdg_ff == WDG_CYCLES) &&
                     (watchdog_selfreset_mode == `MBCFG_MODE_SELFRST);
    end
  end

  // Receiver: sample mid-bit, data LSB first, then parity and stop bits.
  always @* begin
    byte_stb = 1'b0;
    byte_val = rx_byte;
    if (rx_st_ff == RX_STOP && tick_ff == 16'h0000 && !stop2_ff && rx) begin
      byte_stb = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (rst_all) begin
      rx_st_ff     <= RX_IDLE;
      tick_ff      <= 16'h0000;
      bit_ff       <= 4'h0;
      shift_ff     <= 10'h000;
      stop2_ff     <= 1'b0;
      byte_cnt_ff  <= 8'h00;
      crc_ff       <= `MBCFG_CRC_INIT;
      gap_ff       <= 4'h0;
      gap_tick_ff  <= 16'h0000;
      in_frame_ff  <= 1'b0;
      frame_err_ff <= 1'b0;
      own_ff       <= 1'b0;
      good_count   <= 15'h0000;
      bad_count    <= 15'h0000;
      pend_bad_ff  <= 1'b0;
      wdg_ff       <= 24'h000000;
    end else if (ce && loaded_ff) begin
      wdg_ff <= (wdg_kick || wdg_error || wdg_ff == WDG_CYCLES) ? 24'h000000 : wdg_ff + 1'b1;
      // Cleared ahead of the frame judgement so a bad frame ending in this cycle still wins.
      if (link_valid && link_ready && link_sel == 3'h5) begin
        pend_bad_ff <= 1'b0;
      end
      case (rx_st_ff)
        RX_IDLE: begin
          if (!rx) begin
            rx_st_ff <= RX_BITS;
            tick_ff  <= hb + hb + hb;  // Lands mid-way in data bit 0.
            bit_ff   <= 4'h0;
          end
        end
        RX_BITS: begin
          if (tick_ff != 16'h0000) begin
            tick_ff <= tick_ff - 1'b1;
          end else begin
            shift_ff <= {rx, shift_ff[9:1]};
            tick_ff  <= hb + hb - 1'b1;
            bit_ff   <= bit_ff + 1'b1;
            if (bit_ff == nbits - 1'b1) begin
              rx_st_ff <= RX_STOP;
              stop2_ff <= (act_parity == `MBCFG_PAR_NONE2);
            end
          end
        end
        RX_STOP: begin
          if (tick_ff != 16'h0000) begin
            tick_ff <= tick_ff - 1'b1;
          end else if (!rx) begin
            frame_err_ff <= 1'b1;
            rx_st_ff     <= RX_IDLE;
          end else if (stop2_ff) begin
            stop2_ff <= 1'b0;
            tick_ff  <= hb + hb - 1'b1;
          end else begin
            rx_st_ff <= RX_IDLE;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
      if (byte_stb) begin
        in_frame_ff <= 1'b1;
        gap_ff      <= 4'h0;
        gap_tick_ff <= 16'h0000;
        byte_cnt_ff <= (byte_cnt_ff == 8'hff) ? byte_cnt_ff : byte_cnt_ff + 1'b1;
        crc_ff      <= crc_byte(crc_ff, rx_byte);
        if (has_par && ((^shift_ff[9:1]) != (act_parity == `MBCFG_PAR_ODD))) begin
          frame_err_ff <= 1'b1;
        end
        if (!fifo_rdy && own_ff) begin
          frame_err_ff <= 1'b1;
        end
        if (byte_cnt_ff == 8'h00) begin
          own_ff <= (rx_byte == act_addr);
        end
      end else if (in_frame_ff && rx_st_ff == RX_IDLE) begin
        // Gap is counted in half characters: 11 bits each half is 11 half-bits.
        if (gap_tick_ff == hb * `MBCFG_BITS_CHAR) begin
          gap_tick_ff <= 16'h0000;
          gap_ff      <= gap_ff + 1'b1;
        end else begin
          gap_tick_ff <= gap_tick_ff + 1'b1;
        end
        if (gap_ff == `MBCFG_GAP_HALFCHARS) begin
          in_frame_ff  <= 1'b0;
          byte_cnt_ff  <= 8'h00;
          crc_ff       <= `MBCFG_CRC_INIT;
          frame_err_ff <= 1'b0;
          own_ff       <= 1'b0;
          gap_ff       <= 4'h0;
          if (frame_err_ff || crc_ff != `MBCFG_CRC_GOOD ||
              {1'b0, byte_cnt_ff} < `MBCFG_FRAME_MIN) begin
            bad_count   <= (bad_count == `MBCFG_CNT_MAX) ? 15'h0000 : bad_count + 1'b1;
            pend_bad_ff <= 1'b1;
          end else begin
            good_count <= (good_count == `MBCFG_CNT_MAX) ? 15'h0000 : good_count + 1'b1;
          end
        end
      end
    end
  end

  // Drive link: configuration once after link comes up, then counters on errors.
  always @(posedge clk) begin
    if (rst_all) begin
      link_seen_ff      <= 1'b0;
      link_valid        <= 1'b0;
      link_sel          <= 3'h0;
      link_data         <= 16'h0000;
      sent_ff           <= 3'h0;
      module_type       <= 16'h0000;
      module_type_valid <= 1'b0;
    end else if (ce && loaded_ff) begin
      if (!link_up) begin
        module_type_valid <= 1'b0;
        link_seen_ff      <= 1'b0;
        link_valid        <= 1'b0;
        sent_ff           <= 3'h0;
      end else if (link_valid) begin
        if (link_ready) begin
          link_valid <= 1'b0;
          sent_ff    <= (sent_ff == 3'h6) ? 3'h5 : sent_ff + 1'b1;
        end
      end else if (!link_seen_ff || sent_ff != 3'h5 || pend_bad_ff) begin
        link_seen_ff      <= 1'b1;
        module_type       <= MODULE_ID;
        module_type_valid <= 1'b1;
        link_valid        <= 1'b1;
        // Step 5 carries the bad count and step 6 the good count that must follow it.
        link_sel          <= (sent_ff == 3'h6) ? 3'h7 : sent_ff;
        case (sent_ff)
          3'h0:    link_data <= {15'h0000, watchdog_selfreset_mode};
          3'h1:    link_data <= {8'h00, act_addr};
          3'h2:    link_data <= {13'h0000, act_baud};
          3'h3:    link_data <= {14'h0000, act_parity};
          3'h4:    link_data <= {15'h0000, optical_channel_select};
          3'h5:    link_data <= {1'b0, bad_count};
          default: link_data <= {1'b0, good_count};
        endcase
      end
    end
  end
endmodule // mbcfg_top
`default_nettype wire

// ===== tb/mbcfg_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbcfg_master_model #(
  parameter int BIT_CYC = 651
) (
  // Clock and serial line
  input  wire logic clk,
  output var  logic rx
);
  initial rx = 1'b1;
  // The line rests high between characters, as a biased bus does.
  task automatic send_char(input logic [7:0] b, input logic [1:0] par);
    logic [10:0] bits;
    int          n;
    bits = par < 2'h2 ? {1'b1, ^b ^ par[0], b, 1'b0} : {2'b11, b, 1'b0};
    n = par == 2'h3 ? 10 : 11;
    for (int i = 0; i < n; i++) begin
      rx <= bits[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
endmodule // mbcfg_master_model
`default_nettype wire

// ===== tb/mbcfg_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mbcfg_top_bench;
  localparam logic [15:0] TYPE_ID = 16'h3c02; // Arbitrary identity value.
  localparam int          BIT     = 651;
  logic        clk, reset, link_up, wdg_kick, link_ready, frm_ready, kick_en;
  logic        cfg_mode, cfg_channel;
  logic [2:0]  cfg_baud;
  logic [1:0]  cfg_parity;
  logic [7:0]  cfg_addr;
  wire         rx, link_valid, frm_valid, wdg_error, module_type_valid;
  wire         watchdog_selfreset_mode, optical_channel_select;
  wire  [2:0]  link_sel, act_baud;
  wire  [1:0]  act_parity;
  wire  [7:0]  frm_data, act_addr;
  wire  [14:0] good_count, bad_count;
  wire  [15:0] link_data, module_type;
  int          mismatches, n_compared, cycles;
  mbcfg_top #(.MODULE_ID(TYPE_ID), .WDG_CYCLES(24'h0000c8)) dut_u (
    .clk, .ce(1'b1), .reset, .rx, .cfg_baud, .cfg_parity, .cfg_addr, .cfg_mode,
    .cfg_channel, .link_up, .wdg_kick, .link_valid, .link_ready, .link_sel, .link_data,
    .frm_valid, .frm_ready, .frm_data, .wdg_error, .module_type, .module_type_valid,
    .good_count, .bad_count, .act_baud, .act_parity, .act_addr, .watchdog_selfreset_mode,
    .optical_channel_select);
  mbcfg_master_model #(.BIT_CYC(BIT)) mdl_u (.clk, .rx);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The shortened watchdog would expire inside every serial frame without kicks.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    wdg_kick <= kick_en && cycles[5:0] == 6'h00;
    if (cycles == 95000) begin
      mismatches++;
      wrap_up;
    end
  end
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < 16; i++) begin
      if (i % 8 == 0) c = c ^ {8'h00, d[i +: 8]};
      c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic do_reset(input logic [2:0] b, input logic [7:0] a, input logic [1:0] p,
                          input logic m);
    reset <= 1'b1;
    cfg_baud <= b;
    cfg_addr <= a;
    cfg_parity <= p;
    cfg_mode <= m;
    cfg_channel <= m;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic send(input logic [7:0] q[$], input logic [15:0] g, input logic [15:0] b);
    logic [15:0] g0;
    g0 = good_count;
    foreach (q[i]) begin
      mdl_u.send_char(q[i], cfg_parity);
    end
    repeat (36 * BIT) @(posedge clk);
    cmp("good_count in gap", g0, good_count);
    repeat (4 * BIT) @(posedge clk);
    cmp("good_count", g, good_count);
    cmp("bad_count", b, bad_count);
  endtask
  task automatic load_settings;
    do_reset(3'h4, 8'h11, 2'h3, 1'b1);
    cmp("act_baud", 16'h4, act_baud);
    cmp("act_parity", 16'h3, act_parity);
    cmp("act_addr", 16'h11, act_addr);
    cmp("selfreset mode", 16'h1, watchdog_selfreset_mode);
    cmp("channel", 16'h1, optical_channel_select);
    cfg_baud <= 3'h0;
    cfg_addr <= 8'h22;
    repeat (4) @(posedge clk);
    cmp("act_baud held", 16'h4, act_baud);
    cmp("act_addr held", 16'h11, act_addr);
    cmp("type valid early", 16'h0, module_type_valid);
  endtask
  task automatic frames;
    logic [15:0] c;
    c = crc16({8'h03, 8'h11});
    send('{8'h11, 8'h03, c[7:0], c[15:8]}, 16'h1, 16'h0);
    cmp("frm_valid", 16'h1, frm_valid);
    cmp("frm_data", 16'h03, frm_data);
    frm_ready <= 1'b1;
    repeat (20) @(posedge clk);
    cmp("fifo drained", 16'h0, frm_valid);
    send('{8'h11}, 16'h1, 16'h1);
  endtask
  task automatic link_config;
    logic [18:0] xs [7];
    int          k;
    xs = '{19'h00001, 19'h10011, 19'h20004, 19'h30003, 19'h40001, 19'h50001, 19'h70001};
    link_up <= 1'b1;
    foreach (xs[i]) begin
      repeat (3) @(posedge clk);
      k = 0;
      while (!link_valid && k < 200) begin
        @(posedge clk);
        k++;
      end
      cmp("link_sel", xs[i][18:16], link_sel);
      cmp("link_data", xs[i][15:0], link_data);
      link_ready <= 1'b1;
      @(posedge clk);
      link_ready <= 1'b0;
    end
    cmp("type valid", 16'h1, module_type_valid);
    cmp("module_type", TYPE_ID, module_type);
  endtask
  task automatic wdg_self;
    kick_en <= 1'b0;
    repeat (300) @(posedge clk);
    kick_en <= 1'b1;
    cmp("good after selfreset", 16'h0, good_count);
    cmp("bad after selfreset", 16'h0, bad_count);
    cmp("wdg_error self", 16'h0, wdg_error);
    cmp("act_addr kept", 16'h11, act_addr);
  endtask
  task automatic wdg_latch;
    do_reset(3'h7, 8'h00, 2'h0, 1'b0);
    cmp("act_baud fallback", 16'h3, act_baud);
    cmp("act_addr fallback", 16'h1, act_addr);
    cmp("act_parity even", 16'h0, act_parity);
    cmp("latch mode", 16'h0, watchdog_selfreset_mode);
    kick_en <= 1'b0;
    repeat (300) @(posedge clk);
    kick_en <= 1'b1;
    cmp("wdg_error set", 16'h1, wdg_error);
    repeat (300) @(posedge clk);
    cmp("wdg_error held", 16'h1, wdg_error);
  endtask
  initial begin
    link_up = 1'b0;
    link_ready = 1'b0;
    frm_ready = 1'b0;
    kick_en = 1'b1;
    load_settings;
    frames;
    link_config;
    wdg_self;
    wdg_latch;
    wrap_up;
  end
endmodule // mbcfg_top_bench
bind mbcfg_top mbcfg_top_props #(.MODULE_ID(MODULE_ID)) props_u (
  .clk, .reset, .link_up, .link_valid, .link_ready, .link_sel, .link_data, .wdg_error,
  .module_type, .module_type_valid, .good_count, .bad_count, .act_baud, .act_parity,
  .act_addr, .watchdog_selfreset_mode);
`default_nettype wire

// ===== tb/mbcfg_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module mbcfg_top_props #(
  parameter logic [15:0] MODULE_ID = 16'h0000
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Drive link
  input wire logic        link_up,
  input wire logic        link_valid,
  input wire logic        link_ready,
  input wire logic [2:0]  link_sel,
  input wire logic [15:0] link_data,
  // Status
  input wire logic        wdg_error,
  input wire logic [15:0] module_type,
  input wire logic        module_type_valid,
  input wire logic [14:0] good_count,
  input wire logic [14:0] bad_count,
  input wire logic [2:0]  act_baud,
  input wire logic [1:0]  act_parity,
  input wire logic [7:0]  act_addr,
  input wire logic        watchdog_selfreset_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic bad_sent_ff;
  sequence take_s(logic [2:0] s);
    link_valid && link_ready && link_sel == s;
  endsequence
  property step_p(logic [14:0] c);
    c != $past(c) |-> c == $past(c) + 15'h1 || c == 15'h0;
  endproperty
  // Cleared by a good count, so each good count needs a fresh bad count ahead of it.
  always @(posedge clk) begin
    if (reset || (link_valid && link_ready && link_sel == 3'h7)) begin
      bad_sent_ff <= 1'b0;
    end else if (link_valid && link_ready && link_sel == 3'h5) begin
      bad_sent_ff <= 1'b1;
    end
  end
  act_hold_a: assert property (!$past(reset, 2) |-> $stable({act_baud, act_parity, act_addr}))
    else $error("Applied settings changed after load.");
  baud_range_a: assert property (act_baud <= 3'h4)
    else $error("Applied baud code out of range.");
  addr_range_a: assert property (act_addr >= 8'h01 && act_addr <= 8'hf7)
    else $error("Applied address out of range.");
  good_step_a: assert property (step_p(good_count))
    else $error("Good count moved by other than one.");
  bad_step_a: assert property (step_p(bad_count))
    else $error("Bad count moved by other than one.");
  error_latch_a: assert property (wdg_error && !watchdog_selfreset_mode |=> wdg_error)
    else $error("Watchdog error dropped.");
  selfrst_clean_a: assert property (watchdog_selfreset_mode |-> !wdg_error)
    else $error("Watchdog error shown in self-reset mode.");
  link_hold_a: assert property (link_valid && !link_ready |=>
    link_valid && $stable(link_sel) && $stable(link_data))
    else $error("Link word changed while stalled.");
  link_gate_a: assert property ($rose(link_valid) |-> $past(link_up))
    else $error("Link word offered without link.");
  good_order_a: assert property (take_s(3'h7) |-> bad_sent_ff)
    else $error("Good count sent without new bad count.");
  type_value_a: assert property (module_type_valid |-> module_type == MODULE_ID)
    else $error("Module type value wrong.");
endmodule // mbcfg_top_props
`default_nettype wire
